// file: logic/astx_pkg.sv
// constants and register map of the serial transmitter/receiver
// Contract
// RULE1: word length 8 or 9 bits
// RULE2: start low, stop high, lsb first
// RULE3: idle is 10 or 11 high bits
// RULE4: ninth bit from/to control bits
// RULE5: break repeats, then one high bit
// RULE6: enabling transmitter sends idle preamble
// RULE7: re-enable mid-word queues preamble after word
// RULE8: software toggles enable only when empty
// RULE9: buffer empty cleared by status then write
// RULE10: write loads holding or shift register
// RULE11: done flag after stop bit
// RULE12: receiver enable starts start-bit search
// RULE13: received char sets receive full
// RULE14: full cleared by status then read
// RULE15: idle line sets idle flag
// RULE16: overrun keeps holding, sets flag
// RULE17: noise flagged with full
// RULE18: missing stop gives framing error
// RULE19: break reads as framing error, 00h
// RULE20: divide by 16, prescaler, power of two
// RULE21: no baud change while enabled
// RULE22: nonzero fine divider divides further
// RULE23: start, data lsb first, one stop
// RULE24: idle line high, pin released disabled
// RULE25: sixteen-fold sampling, majority of three
// RULE26: start bit confirmed at centre
`default_nettype none
package astx_pkg;
  localparam logic [7:0] ADDR_FLAG = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_CTRL1 = 8'h0c;
  localparam logic [7:0] ADDR_CTRL2 = 8'h10;
  localparam logic [7:0] ADDR_TXFINE = 8'h14;
  localparam logic [7:0] ADDR_RXFINE = 8'h18;
  // flag register bits
  localparam int F_TXE = 7;
  localparam int F_TXDONE = 6;
  localparam int F_RXFULL = 5;
  localparam int F_IDLE = 4;
  localparam int F_OVR = 3;
  localparam int F_NOISE = 2;
  localparam int F_FRAME = 1;
  localparam logic [7:0] FLAG_RESET = 8'hc0;
  // ctrl one bits
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_WORD9 = 4;
  // ctrl two bits
  localparam int C2_TXEIE = 7;
  localparam int C2_TXDIE = 6;
  localparam int C2_RXIE = 5;
  localparam int C2_IDLEIE = 4;
  localparam int C2_TXON = 3;
  localparam int C2_RXON = 2;
  localparam int C2_BRK = 0;
  // baud fields
  localparam int B_COMMON_LO = 6;
  localparam int B_TX_LO = 3;
  localparam int B_RX_LO = 0;
  localparam int OVERSAMPLE = 16;
  localparam int BITS8_FRAME = 10;
  localparam int BITS9_FRAME = 11;
  localparam logic [7:0] BREAK_DATA = 8'h00;
endpackage
`default_nettype wire

// file: logic/astx_uart.sv
// serial transmitter/receiver with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module astx_uart
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serial_in_pin,
  output logic txOut,
  output logic txOutEn,
  output logic irqReq
);
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_PRE = 2'b01, TX_SHIFT = 2'b10, TX_MARK = 2'b11} astx_tx_t;
  typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} astx_rx_t;
  typedef struct packed {
    logic aPend; logic aWr; logic [7:0] aAddr;
    logic [31:0] rdata;
    logic statSeen;
    logic [7:0] flags; logic [7:0] ctrl1; logic [7:0] ctrl2; logic [7:0] baud;
    logic [7:0] txFine; logic [7:0] rxFine;
    logic [8:0] txHold; logic [8:0] rxHold;
    logic txOnPrev;
    // transmitter
    astx_tx_t txSt; logic [10:0] txSh; logic [3:0] txCnt; logic [3:0] txSub; logic txLine;
    logic prePend; logic brk;
    logic [12:0] txDiv; logic [7:0] txFineCnt;
    // receiver
    astx_rx_t rxSt; logic [8:0] rxSh; logic [3:0] rxCnt; logic [3:0] rxSub;
    logic [2:0] samp; logic noisy; logic [3:0] idleCnt; logic idleArm;
    logic [12:0] rxDiv; logic [7:0] rxFineCnt;
    logic [1:0] pinSync;
  } astx_state_t;
  astx_state_t s_q, s_d;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [12:0] divLimit(input logic [1:0] common, input logic [2:0] pw);
    logic [12:0] pr;
    begin
      pr = 13'd1;
      case (common)
        2'd0: pr = 13'd1;
        2'd1: pr = 13'd3;
        2'd2: pr = 13'd4;
        2'd3: pr = 13'd13;
        default: pr = 13'd1;
      endcase
      divLimit = 13'(pr << pw) - 13'd1;
    end
  endfunction
  function automatic logic major3(input logic [2:0] v);
    major3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  //////////////////////////////////////////////////////////////////////
  logic txTick, rxTick, word9, acc, rdDataAcc, wrDataAcc;
  logic [3:0] frameLen;
  logic [8:0] wdat;
  logic rxBit, rxLine;
  always_comb
  begin
    s_d = s_q;
    word9 = s_q.ctrl1[astx_pkg::C1_WORD9];
    // RULE3: idle length per word size
    frameLen = word9 ? 4'(astx_pkg::BITS9_FRAME) : 4'(astx_pkg::BITS8_FRAME);
    acc = hsel & hready & htrans[1];
    rdDataAcc = s_q.aPend & ~s_q.aWr & (s_q.aAddr == astx_pkg::ADDR_DATA);
    wrDataAcc = s_q.aPend & s_q.aWr & (s_q.aAddr == astx_pkg::ADDR_DATA);
    // 8-bit words: top shift bit doubles as the stop bit
    wdat = {s_q.ctrl1[astx_pkg::C1_TX9] | ~word9, hwdata[7:0]};
    rxLine = s_q.pinSync[1];
    rxBit = major3(s_q.samp);
    txTick = 1'b0;
    rxTick = 1'b0;
    // bus address phase capture
    s_d.aPend = acc;
    s_d.aWr = hwrite;
    s_d.aAddr = haddr[7:0];
    if (acc & ~hwrite)
    begin
      case (haddr[7:0])
        astx_pkg::ADDR_FLAG: s_d.rdata = {24'h0, s_q.flags};
        astx_pkg::ADDR_DATA: s_d.rdata = {24'h0, s_q.rxHold[7:0]};
        astx_pkg::ADDR_BAUD: s_d.rdata = {24'h0, s_q.baud};
        astx_pkg::ADDR_CTRL1: s_d.rdata = {24'h0, s_q.rxHold[8], s_q.ctrl1[6:0]};
        astx_pkg::ADDR_CTRL2: s_d.rdata = {24'h0, s_q.ctrl2};
        astx_pkg::ADDR_TXFINE: s_d.rdata = {24'h0, s_q.txFine};
        astx_pkg::ADDR_RXFINE: s_d.rdata = {24'h0, s_q.rxFine};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (acc & (haddr[7:0] == astx_pkg::ADDR_FLAG))
    begin
      s_d.statSeen = 1'b1;
    end
    // RULE21: baud fields written only by software
    if (s_q.aPend & s_q.aWr)
    begin
      case (s_q.aAddr)
        astx_pkg::ADDR_BAUD: s_d.baud = hwdata[7:0];
        astx_pkg::ADDR_CTRL1: s_d.ctrl1 = {s_q.ctrl1[7], hwdata[6:0]};
        astx_pkg::ADDR_CTRL2: s_d.ctrl2 = hwdata[7:0];
        astx_pkg::ADDR_TXFINE: s_d.txFine = hwdata[7:0];
        astx_pkg::ADDR_RXFINE: s_d.rxFine = hwdata[7:0];
        default: s_d.statSeen = s_q.statSeen;
      endcase
    end
    // flag clears by status then data access (event set below wins)
    // RULE9: status then write clears empty/done
    if (wrDataAcc & s_q.statSeen)
    begin
      s_d.flags[astx_pkg::F_TXE] = 1'b0;
      s_d.flags[astx_pkg::F_TXDONE] = 1'b0;
      s_d.statSeen = 1'b0;
    end
    // RULE14: status then read clears receive flags
    if (rdDataAcc & s_q.statSeen)
    begin
      s_d.flags[5:1] = 5'h0;
      s_d.statSeen = 1'b0;
    end
    //////////////////////////////////////////////////////////////////
    // RULE20: divide by 16, prescaler and power of two
    s_d.txDiv = s_q.txDiv + 13'd1;
    if (s_q.txDiv >= divLimit(s_q.baud[7:6], s_q.baud[5:3]))
    begin
      s_d.txDiv = 13'h0;
      // RULE22: fine divider when nonzero
      if (s_q.txFine == 8'h00 || s_q.txFineCnt >= s_q.txFine - 8'd1)
      begin
        s_d.txFineCnt = 8'h0;
        txTick = 1'b1;
      end
      else
      begin
        s_d.txFineCnt = s_q.txFineCnt + 8'd1;
      end
    end
    s_d.rxDiv = s_q.rxDiv + 13'd1;
    if (s_q.rxDiv >= divLimit(s_q.baud[7:6], s_q.baud[2:0]))
    begin
      s_d.rxDiv = 13'h0;
      if (s_q.rxFine == 8'h00 || s_q.rxFineCnt >= s_q.rxFine - 8'd1)
      begin
        s_d.rxFineCnt = 8'h0;
        rxTick = 1'b1;
      end
      else
      begin
        s_d.rxFineCnt = s_q.rxFineCnt + 8'd1;
      end
    end
    //////////////////////////////////////////////////////////////////
    // transmitter
    s_d.txOnPrev = s_q.ctrl2[astx_pkg::C2_TXON];
    // RULE6: rising enable queues preamble
    if (s_q.ctrl2[astx_pkg::C2_TXON] & ~s_q.txOnPrev)
    begin
      s_d.prePend = 1'b1;
      // RULE8: enabling (rising edge only) drops held data
      s_d.flags[astx_pkg::F_TXE] = 1'b1;
    end
    if (txTick)
    begin
      s_d.txSub = s_q.txSub + 4'd1;
      if (s_q.txSub == 4'(astx_pkg::OVERSAMPLE - 1))
      begin
        s_d.txCnt = s_q.txCnt + 4'd1;
        case (s_q.txSt)
          TX_PRE:
          begin
            s_d.txLine = 1'b1;
            if (s_q.txCnt == frameLen - 4'd1)
            begin
              s_d.txSt = TX_IDLE;
            end
          end
          TX_SHIFT:
          begin
            // RULE2: lsb first then stop high
            s_d.txLine = s_q.txSh[0];
            s_d.txSh = {1'b1, s_q.txSh[10:1]};
            // RULE1: word length selects count
            // RULE23: start, data, one stop
            if (s_q.txCnt == frameLen - 4'd1)
            begin
              s_d.txSt = TX_IDLE;
              s_d.txLine = 1'b1;
              if (!s_q.brk)
              begin
                // RULE11: done after stop bit
                s_d.flags[astx_pkg::F_TXDONE] = 1'b1;
              end
            end
          end
          TX_MARK:
          begin
            s_d.txLine = 1'b1;
            s_d.txSt = TX_IDLE;
          end
          default: s_d.txSt = TX_IDLE;
        endcase
      end
      if (s_q.txSub == 4'(astx_pkg::OVERSAMPLE - 1) && s_d.txSt == TX_IDLE)
      begin
        s_d.txCnt = 4'h0;
        if (!s_q.ctrl2[astx_pkg::C2_TXON])
        begin
          s_d.prePend = 1'b0;
        end
        else if (s_q.ctrl2[astx_pkg::C2_BRK])
        begin
          // RULE5: keep sending breaks
          s_d.brk = 1'b1;
          s_d.txSt = TX_SHIFT;
          s_d.txSh = 11'h0;
          s_d.txLine = 1'b0;
        end
        else if (s_q.brk)
        begin
          // RULE5: one high bit after break
          s_d.brk = 1'b0;
          s_d.txSt = TX_MARK;
          s_d.txLine = 1'b1;
        end
        else if (s_q.prePend)
        begin
          // RULE7: preamble after current word
          s_d.prePend = 1'b0;
          s_d.txSt = TX_PRE;
          s_d.txLine = 1'b1;
        end
        else if (!s_q.flags[astx_pkg::F_TXE])
        begin
          // RULE4: ninth bit carried in holding
          s_d.txSh = {2'b11, s_q.txHold};
          s_d.txSt = TX_SHIFT;
          s_d.txLine = 1'b0;
          s_d.flags[astx_pkg::F_TXE] = 1'b1;
        end
      end
    end
    // RULE10: write to holding or shift register
    // after the tick logic so a direct start keeps a full start bit
    if (wrDataAcc)
    begin
      if (s_q.txSt == TX_IDLE && s_d.txSt == TX_IDLE && !s_q.prePend && s_q.ctrl2[astx_pkg::C2_TXON])
      begin
        s_d.txSh = {2'b11, wdat};
        s_d.txSt = TX_SHIFT;
        s_d.txLine = 1'b0;
        s_d.txCnt = 4'h0;
        s_d.txSub = 4'h0;
        s_d.flags[astx_pkg::F_TXE] = 1'b1;
      end
      else
      begin
        s_d.txHold = wdat;
      end
    end
    if (!s_q.ctrl2[astx_pkg::C2_TXON] && s_q.txSt == TX_PRE)
    begin
      s_d.txSt = TX_IDLE;
    end
    //////////////////////////////////////////////////////////////////
    // receiver
    s_d.pinSync = {s_q.pinSync[0], serial_in_pin};
    if (!s_q.ctrl2[astx_pkg::C2_RXON])
    begin
      s_d.rxSt = RX_HUNT;
      s_d.idleCnt = 4'h0;
      s_d.idleArm = 1'b0;
    end
    else if (rxTick)
    begin
      s_d.rxSub = s_q.rxSub + 4'd1;
      // RULE25: three centre samples
      if (s_q.rxSub >= 4'd7 && s_q.rxSub <= 4'd9)
      begin
        s_d.samp = {s_q.samp[1:0], rxLine};
      end
      case (s_q.rxSt)
        RX_HUNT:
        begin
          s_d.rxSub = 4'h0;
          // RULE12: search for start
          if (!rxLine)
          begin
            s_d.rxSt = RX_START;
            s_d.rxSub = 4'd1;
            s_d.noisy = 1'b0;
          end
          else if (s_q.rxSub == 4'h0)
          begin
            s_d.rxSub = 4'h0;
          end
        end
        RX_START:
        begin
          if (s_q.rxSub == 4'd15)
          begin
            // RULE26: confirm start at centre
            if (rxBit)
            begin
              s_d.rxSt = RX_HUNT;
            end
            else
            begin
              s_d.rxSt = RX_DATA;
              s_d.rxCnt = 4'h0;
              s_d.noisy = s_q.samp != 3'b000;
            end
          end
        end
        RX_DATA:
        begin
          if (s_q.rxSub == 4'd15)
          begin
            s_d.rxSh = word9 ? {rxBit, s_q.rxSh[8:1]} : {1'b0, rxBit, s_q.rxSh[7:1]};
            // RULE25: disagreeing samples are noise
            s_d.noisy = s_q.noisy | (s_q.samp != 3'b000 && s_q.samp != 3'b111);
            s_d.rxCnt = s_q.rxCnt + 4'd1;
            if (s_q.rxCnt == frameLen - 4'd3)
            begin
              s_d.rxSt = RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (s_q.rxSub == 4'd9)
          begin
            s_d.rxSt = RX_HUNT;
            s_d.rxSub = 4'h0;
            s_d.idleCnt = 4'h0;
            s_d.idleArm = 1'b1;
            if (s_q.flags[astx_pkg::F_RXFULL] && !(rdDataAcc & s_q.statSeen))
            begin
              // RULE16: overrun keeps holding
              s_d.flags[astx_pkg::F_OVR] = 1'b1;
            end
            else
            begin
              // RULE13: move to holding, set full
              s_d.rxHold = s_q.rxSh;
              s_d.flags[astx_pkg::F_RXFULL] = 1'b1;
              // RULE17: noise flagged with full
              s_d.flags[astx_pkg::F_NOISE] = s_q.noisy | (s_d.samp != 3'b000 && s_d.samp != 3'b111);
              // RULE18: missing stop is framing error
              // RULE19: break gives data 00h
              s_d.flags[astx_pkg::F_FRAME] = ~major3(s_d.samp);
              // RULE4: ninth bit to control
              s_d.ctrl1[astx_pkg::C1_RX9] = s_q.rxSh[8];
            end
          end
        end
        default: s_d.rxSt = RX_HUNT;
      endcase
      // RULE15: idle line after full frame of highs
      if (s_q.rxSt == RX_HUNT && s_q.idleArm)
      begin
        if (!rxLine)
        begin
          s_d.idleCnt = 4'h0;
        end
        else if (s_q.rxSub == 4'd15)
        begin
          s_d.idleCnt = s_q.idleCnt + 4'd1;
          if (s_q.idleCnt == frameLen - 4'd1)
          begin
            s_d.idleArm = 1'b0;
            s_d.flags[astx_pkg::F_IDLE] = 1'b1;
          end
        end
        if (rxLine)
        begin
          s_d.rxSub = s_q.rxSub + 4'd1;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.flags <= astx_pkg::FLAG_RESET;
      s_q.txLine <= 1'b1;
      s_q.pinSync <= 2'b11;
      s_q.samp <= 3'b111;
    end
    else if (clkEn)
    begin
      s_q <= s_d;
    end
  end
  //////////////////////////////////////////////////////////////////////
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // RULE24: high at rest, released when off
  assign txOut = s_q.txLine;
  assign txOutEn = s_q.ctrl2[astx_pkg::C2_TXON];
  assign irqReq = (s_q.flags[astx_pkg::F_TXE] & s_q.ctrl2[astx_pkg::C2_TXEIE])
    | (s_q.flags[astx_pkg::F_TXDONE] & s_q.ctrl2[astx_pkg::C2_TXDIE])
    | ((s_q.flags[astx_pkg::F_RXFULL] | s_q.flags[astx_pkg::F_OVR]) & s_q.ctrl2[astx_pkg::C2_RXIE])
    | (s_q.flags[astx_pkg::F_IDLE] & s_q.ctrl2[astx_pkg::C2_IDLEIE]);
endmodule // astx_uart
`default_nettype wire

// file: tb/astx_uart_assertions.sv
// port-level assertions for the serial block
`timescale 1ns/1ps
`default_nettype none
module astx_uart_checker
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serial_in_pin,
  input wire logic txOut,
  input wire logic txOutEn,
  input wire logic irqReq
);
  logic ctlPh_q, ctlSeen_q, expEn_q;
  wire logic ctlWr = hsel && hready && htrans[1] && hwrite && clkEn && haddr[7:0] == astx_pkg::ADDR_CTRL2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // control writes seen in data phase
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ctlPh_q <= 1'b0;
      ctlSeen_q <= 1'b0;
      expEn_q <= 1'b0;
    end
    else
    begin
      ctlPh_q <= ctlWr;
      ctlSeen_q <= ctlSeen_q || ctlWr;
      if (ctlPh_q)
        expEn_q <= hwdata[astx_pkg::C2_TXON];
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_start_hold: assert property ($fell(txOut) |-> !txOut [*8])
    else $error("low bit too short");
  a_mark_hold: assert property ($rose(txOut) && txOutEn |-> txOut [*8])
    else $error("high bit too short");
  a_preamble_high: assert property ($rose(txOutEn) |-> txOut [*8])
    else $error("no idle preamble");
  a_enable_follows: assert property (ctlPh_q |-> ##[1:2] txOutEn == expEn_q)
    else $error("pin enable not following control");
  a_irq_quiet: assert property (!ctlSeen_q |-> !irqReq)
    else $error("interrupt without enable");
  a_freeze_hold: assert property (!clkEn |=> $stable(txOut) && $stable(txOutEn))
    else $error("line moved while frozen");
  a_released_high: assert property (!txOutEn |-> txOut)
    else $error("released line not high");
  c_frame: cover property ($fell(txOut));
  c_enable: cover property ($rose(txOutEn));
  c_irq: cover property ($rose(irqReq));
endmodule // astx_uart_checker
bind astx_uart astx_uart_checker chk
(
  .core_clk(core_clk), .reset(reset), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(serial_in_pin),
  .txOut(txOut), .txOutEn(txOutEn), .irqReq(irqReq)
);
`default_nettype wire

// file: tb/astx_remote_node.sv
// remote serial node on the far end of the line
`timescale 1ns/1ps
`default_nettype none
module astx_remote_node
#(
  parameter int BIT = 16
)
(
  input wire logic core_clk,
  input wire logic txLine,
  output var logic rxLine
);
  initial rxLine = 1'b1;
  task automatic sendChar(input logic [8:0] d, input int n, input logic stopBit);
    @(posedge core_clk);
    rxLine <= 1'b0;
    for (int i = 0; i <= n; i++)
    begin
      repeat (BIT) @(posedge core_clk);
      rxLine <= (i == n) ? stopBit : d[i];
    end
    repeat (BIT) @(posedge core_clk);
    rxLine <= 1'b1;
  endtask
  task automatic getChar(input int n, output logic [8:0] d, output logic stopBit);
    d = 9'h0;
    @(posedge core_clk);
    while (txLine !== 1'b0)
      @(posedge core_clk);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT) @(posedge core_clk);
      d[i] = txLine;
    end
    repeat (BIT) @(posedge core_clk);
    stopBit = txLine;
  endtask
endmodule // astx_remote_node
`default_nettype wire

// file: tb/astx_uart_tb.sv
// self-checking bench for the serial block
`timescale 1ns/1ps
`default_nettype none
module astx_uart_tb;
  logic core_clk, reset, clkEn, hsel, hwrite, hreadyout, hresp, rxLine, txOut, txOutEn, irqReq, s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [8:0] d;
  int mismatches, testsRun, n;
  astx_uart uut
  (
    .core_clk(core_clk), .reset(reset), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(rxLine),
    .txOut(txOut), .txOutEn(txOutEn), .irqReq(irqReq)
  );
  astx_remote_node #(.BIT(16)) peer
  (
    .core_clk(core_clk),
    .txLine(txOut),
    .rxLine(rxLine)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    report_and_stop;
  end
  task automatic report_and_stop;
    if (mismatches == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
      @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
      @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 32'h0, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    logic [31:0] r;
    xfer(a, 1'b1, w, r);
  endtask
  task automatic waitTx(input logic lvl);
    n = 0;
    while (txOut !== lvl && n < 4000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 4000)
    begin
      mismatches++;
      report_and_stop;
    end
  endtask
  task automatic t_tx;
    rd(astx_pkg::ADDR_FLAG, v);
    check(v, {24'h0, astx_pkg::FLAG_RESET});
    rd(8'h1c, v);
    check(v, 32'h0);
    wr(astx_pkg::ADDR_CTRL2, 32'h2c);
    fork
      begin
        rd(astx_pkg::ADDR_FLAG, v);
        wr(astx_pkg::ADDR_DATA, 32'ha5);
      end
      begin
        waitTx(1'b0);
        peer.getChar(8, d, s);
      end
    join
    check(32'(n >= 155), 32'h1);
    check(d, 9'h0a5);
    check(s, 1'b1);
    repeat (32) @(posedge core_clk);
    rd(astx_pkg::ADDR_FLAG, v);
    check(v[7:6], 2'b11);
    wr(astx_pkg::ADDR_DATA, 32'h3c);
    rd(astx_pkg::ADDR_FLAG, v);
    check(v[7:6], 2'b10);
    peer.getChar(8, d, s);
    check(d, 9'h03c);
    repeat (16) @(posedge core_clk);
  endtask
  task automatic t_nine;
    wr(astx_pkg::ADDR_CTRL1, 32'h50);
    rd(astx_pkg::ADDR_FLAG, v);
    wr(astx_pkg::ADDR_DATA, 32'h5a);
    peer.getChar(9, d, s);
    check(d, 9'h15a);
    check(s, 1'b1);
    peer.sendChar(9'h1c3, 9, 1'b1);
    rd(astx_pkg::ADDR_CTRL1, v);
    check(v[7], 1'b1);
    rd(astx_pkg::ADDR_FLAG, v);
    rd(astx_pkg::ADDR_DATA, v);
    check(v, 32'hc3);
    wr(astx_pkg::ADDR_CTRL1, 32'h0);
  endtask
  task automatic t_rx;
    peer.sendChar(9'h096, 8, 1'b1);
    check(irqReq, 1'b1);
    clkEn <= 1'b0;
    repeat (5) @(posedge core_clk);
    clkEn <= 1'b1;
    rd(astx_pkg::ADDR_FLAG, v);
    check(v[5], 1'b1);
    rd(astx_pkg::ADDR_DATA, v);
    check(v, 32'h96);
    rd(astx_pkg::ADDR_FLAG, v);
    check({irqReq, v[5]}, 2'b00);
    repeat (200) @(posedge core_clk);
    rd(astx_pkg::ADDR_FLAG, v);
    check(v[4], 1'b1);
  endtask
  task automatic t_errors;
    peer.sendChar(9'h011, 8, 1'b1);
    peer.sendChar(9'h022, 8, 1'b1);
    rd(astx_pkg::ADDR_FLAG, v);
    check({v[5], v[3]}, 2'b11);
    rd(astx_pkg::ADDR_DATA, v);
    check(v, 32'h11);
    rd(astx_pkg::ADDR_FLAG, v);
    check(v[3], 1'b0);
    peer.sendChar(9'h000, 8, 1'b0);
    rd(astx_pkg::ADDR_FLAG, v);
    check(v[1], 1'b1);
    rd(astx_pkg::ADDR_DATA, v);
    check(v, 32'h0);
  endtask
  task automatic t_break_baud;
    wr(astx_pkg::ADDR_CTRL2, 32'h2d);
    repeat (320) @(posedge core_clk);
    check(txOut, 1'b0);
    wr(astx_pkg::ADDR_CTRL2, 32'h2c);
    waitTx(1'b1);
    check(32'(n < 200), 32'h1);
    repeat (40) @(posedge core_clk);
    wr(astx_pkg::ADDR_CTRL2, 32'h0);
    wr(astx_pkg::ADDR_BAUD, 32'h08);
    wr(astx_pkg::ADDR_TXFINE, 32'h3);
    wr(astx_pkg::ADDR_CTRL2, 32'h08);
    rd(astx_pkg::ADDR_FLAG, v);
    wr(astx_pkg::ADDR_DATA, 32'h01);
    waitTx(1'b0);
    waitTx(1'b1);
    check(n, 96);
  endtask
  initial
  begin
    reset = 1'b1;
    clkEn = 1'b1;
    hsel = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    mismatches = 0;
    testsRun = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_tx;
    t_nine;
    t_rx;
    t_errors;
    t_break_baud;
    report_and_stop;
  end
endmodule // astx_uart_tb
`default_nettype wire
